// *** memory_mirror_spare_control_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module memory_mirror_spare_control_tb_top
  import mmsc_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic mode_mirror = 1'b0;
  logic mode_spare = 1'b0;
  logic org_x8 = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [23:0] req_addr = 24'h0;
  logic [DW-1:0] req_wdata = 32'h0;
  logic [BW-1:0] spare_bank = 2'h3;
  logic [15:0] cap_installed = 16'h0400;
  logic [15:0] cap_spare = 16'h0100;
  logic req_ready, rsp_valid, rsp_err, mem_valid, mem_write, mem_cmd_par, mem_ack;
  logic mem_link_err, mem_rsp_par, log_valid, mirror_test_en, cfg_conflict, er;
  logic [DW-1:0] rsp_rdata, mem_wdata, mem_rdata, rd;
  logic [BW-1:0] mem_bank, log_bank;
  logic [21:0] mem_addr;
  logic [CW-1:0] mem_wcheck, mem_rcheck;
  logic [NSYM-1:0] mem_bad;
  logic [15:0] cap_usable;
  mmsc_log_t log_kind;
  logic [2:0] cq[$];
  logic [4:0] lq[$];
  int failures = 0;
  int n_tests = 0;

  mmsc_redundancy_ctrl #(.COPY_WORDS(4)) dut_u (
    .clk, .srst, .mode_mirror, .mode_spare, .org_x8, .spare_bank, .cap_installed,
    .cap_spare, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready, .rsp_valid,
    .rsp_rdata, .rsp_err, .mem_valid, .mem_write, .mem_bank, .mem_addr, .mem_wdata,
    .mem_wcheck, .mem_cmd_par, .mem_ack, .mem_link_err, .mem_rdata, .mem_rcheck,
    .mem_bad, .mem_rsp_par, .log_valid, .log_kind, .log_bank, .mirror_test_en,
    .cap_usable, .cfg_conflict);
  mmsc_dimm_model mdl_u (
    .clk, .org_x8, .mem_valid, .mem_write, .mem_bank, .mem_addr, .mem_wdata, .mem_wcheck,
    .mem_ack, .mem_link_err, .mem_rdata, .mem_rcheck, .mem_bad, .mem_rsp_par);

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Logged commands and events; parity is judged on every command issued.
  always @(posedge clk) begin
    if (mem_valid === 1'b1) begin
      cq.push_back({mem_write, mem_bank});
      chk("cmd_par", ^{mem_write, mem_bank, mem_addr, mem_wdata, mem_wcheck}, mem_cmd_par);
    end
    if (log_valid === 1'b1) lq.push_back({log_kind, log_bank});
  end

  function automatic logic seen(input logic [2:0] k, input logic [1:0] b, input logic anyb);
    seen = 1'b0;
    foreach (lq[i]) if (lq[i][4:2] == k && (anyb || lq[i][1:0] == b)) seen = 1'b1;
  endfunction : seen

  // Requests are held until an edge samples ready high; the extra edge lets event logging land.
  task automatic op(input logic w, input logic [23:0] a, input logic [DW-1:0] d);
    int n;
    n = 0;
    {req_valid, req_write, req_addr, req_wdata} <= {1'b1, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 6000) chk("handshake", 1, 0);
    {rd, er} = {rsp_rdata, rsp_err};
    @(posedge clk);
  endtask : op

  task automatic rst(input logic mir, input logic spr);
    {srst, mode_mirror, mode_spare} <= {1'b1, mir, spr};
    for (int b = 0; b < NBANK; b++) mdl_u.bad[b] <= 8'h00;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    cq.delete();
    lq.delete();
  endtask : rst

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_cfg();
    rst(1'b1, 1'b1);
    chk("conflict", 1, cfg_conflict);
    op(1'b1, 24'h800001, 32'h1);
    chk("no_dup", 32'he, {cq.size(), cq[0]});
    rst(1'b0, 1'b1);
    chk("conflict", 0, cfg_conflict);
    chk("cap_spare", 16'h0300, cap_usable);
    $display("test cfg done");
  endtask : t_cfg

  task automatic t_mirror();
    rst(1'b1, 1'b0);
    chk("test_en", 0, mirror_test_en);
    chk("cap_half", 16'h0200, cap_usable);
    op(1'b1, 24'h000001, 32'ha5a50001);
    chk("wr_order", 32'ha5, {cq.size(), cq[0], cq[1]});
    cq.delete();
    repeat (2) op(1'b0, 24'h000001, 32'h0);
    chk("rd_data", 32'ha5a50001, rd);
    chk("rd_copies", 32'h81, {cq.size(), cq[0], cq[1]});
    mdl_u.bad[0] <= 8'h03;
    lq.delete();
    op(1'b0, 24'h000001, 32'h0);
    chk("fo_data", 32'ha5a50001, rd);
    chk("fo_err", 0, er);
    chk("fo_log", 32'h2, {seen(MMSC_LOG_FAILOVER, 0, 1), seen(MMSC_LOG_UE, 0, 1)});
    chk("ce_log", 1, seen(MMSC_LOG_CE, 0, 1));
    cq.delete();
    op(1'b1, 24'h000001, 32'h5a5a0002);
    op(1'b0, 24'h000001, 32'h0);
    chk("fo_rd", 32'h5a5a0002, rd);
    chk("fo_cmds", 32'ha9, {cq.size(), cq[0], cq[1]});
    op(1'b1, 24'h800002, 32'hc3c30003);
    mdl_u.bad[3] <= 8'h30;
    repeat (2) op(1'b0, 24'h800002, 32'h0);
    chk("fm_data", 32'hc3c30003, rd);
    cq.delete();
    op(1'b1, 24'h800002, 32'h3c3c0004);
    op(1'b0, 24'h800002, 32'h0);
    chk("fm_rd", 32'h3c3c0004, rd);
    chk("fm_cmds", 32'hb2, {cq.size(), cq[0], cq[1]});
    $display("test mirror done");
  endtask : t_mirror

  task automatic t_both();
    rst(1'b1, 1'b0);
    op(1'b1, 24'h000002, 32'h11112222);
    mdl_u.bad[0] <= 8'h03;
    mdl_u.bad[1] <= 8'h0c;
    op(1'b0, 24'h000002, 32'h0);
    chk("both_err", 1, er);
    chk("both_log", 1, seen(MMSC_LOG_UE, 0, 1));
    $display("test both done");
  endtask : t_both

  task automatic t_link();
    rst(1'b0, 1'b0);
    mdl_u.nerr <= 2;
    mdl_u.dly <= 3;
    op(1'b1, 24'h400003, 32'h0f0f0005);
    chk("rt_cmds", 32'h3, {er, 4'(cq.size())});
    op(1'b0, 24'h400003, 32'h0);
    chk("rt_rd", 32'h0f0f0005, rd);
    cq.delete();
    mdl_u.nerr <= 4;
    op(1'b1, 24'h400003, 32'h0f0f0006);
    chk("rt_fail", 32'h14, {er, 4'(cq.size())});
    chk("rt_ue", 1, seen(MMSC_LOG_UE, 0, 1));
    mdl_u.dly <= 0;
    $display("test link done");
  endtask : t_link

  task automatic t_ecc();
    rst(1'b0, 1'b0);
    op(1'b1, 24'h000000, 32'h12345678);
    mdl_u.bad[0] <= 8'h20;
    op(1'b0, 24'h000000, 32'h0);
    chk("x4_fix", 32'h2468acf0, {rd[30:0], er});
    org_x8 <= 1'b1;
    mdl_u.bad[0] <= 8'h00;
    op(1'b1, 24'h000000, 32'h9abcdef0);
    mdl_u.bad[0] <= 8'h04;
    op(1'b0, 24'h000000, 32'h0);
    chk("x8_fix", 32'h3579bde0, {rd[30:0], er});
    org_x8 <= 1'b0;
    $display("test ecc done");
  endtask : t_ecc

  task automatic t_spare();
    rst(1'b0, 1'b1);
    op(1'b1, 24'h400000, 32'h77778888);
    mdl_u.bad[1] <= 8'h01;
    repeat (3) op(1'b0, 24'h400000, 32'h0);
    chk("no_copy", 0, seen(MMSC_LOG_SPARE_START, 0, 1));
    op(1'b0, 24'h400000, 32'h0);
    repeat (60) @(posedge clk);
    mdl_u.bad[1] <= 8'hff;
    op(1'b0, 24'h400000, 32'h0);
    chk("copy_log", 1, seen(MMSC_LOG_SPARE_START, 1, 0));
    chk("spare_rd", 32'h77778888, rd);
    chk("spare_bank", 3'h3, cq[$]);
    chk("done_log", 1, seen(MMSC_LOG_SPARE_DONE, 3, 0));
    chk("cap_kept", 16'h0300, cap_usable);
    $display("test spare done");
  endtask : t_spare

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20) @(posedge clk);
    t_cfg();
    t_mirror();
    t_both();
    t_link();
    t_ecc();
    t_spare();
    end_of_test();
  end

  // The scenarios need a few hundred cycles; this 50000-cycle bound only catches a hang.
  initial begin
    #500000;
    failures++;
    end_of_test();
  end
endmodule : memory_mirror_spare_control_tb_top
`default_nettype wire

// *** mmsc_ce_counter.sv ***
`timescale 1ns/100ps
`default_nettype none
module mmsc_ce_counter
  import mmsc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  mmsc_cnt_if.cnt  port_if
);
  logic [CNTW-1:0] count;
  logic [CNTW-1:0] next_count;

  // An error in the clearing cycle still counts, so the set side wins.
  always_comb begin
    next_count = count;
    if (port_if.clr) begin
      next_count = '0;
    end
    if (port_if.inc && next_count != CE_LIMIT) begin
      next_count = next_count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // The count saturates at the threshold so the flag cannot wrap away.
  assign port_if.hit = (count == CE_LIMIT);
endmodule : mmsc_ce_counter
`default_nettype wire

// *** mmsc_cnt_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// Strobes to one per-bank error counter and its threshold flag.
interface mmsc_cnt_if;
  logic inc;
  logic clr;
  logic hit;
  modport ctrl (output inc, output clr, input hit);
  modport cnt  (input inc, input clr, output hit);
endinterface : mmsc_cnt_if
`default_nettype wire

// *** mmsc_dimm_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Buffered DIMM set: four banks of four words, answering each command after dly idle cycles.
module mmsc_dimm_model
  import mmsc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          org_x8,
  input  wire logic          mem_valid,
  input  wire logic          mem_write,
  input  wire logic [BW-1:0] mem_bank,
  input  wire logic [21:0]   mem_addr,
  input  wire logic [DW-1:0] mem_wdata,
  input  wire logic [CW-1:0] mem_wcheck,
  output logic               mem_ack,
  output logic               mem_link_err,
  output logic [DW-1:0]      mem_rdata,
  output logic [CW-1:0]      mem_rcheck,
  output logic [NSYM-1:0]    mem_bad,
  output logic               mem_rsp_par
);
  logic [DW+CW-1:0] store [NBANK][4];
  logic [NSYM-1:0]  bad [NBANK];
  logic [DW+CW-1:0] cdat;
  logic [DW+CW-1:0] rd;
  logic [BW-1:0]    cb;
  logic [1:0]       ca;
  logic             cw;
  logic             busy;
  int               nerr;
  int               dly;
  int               cnt;

  // Failed DRAMs corrupt their whole symbol; one org_x8 for all banks keeps a bank uniform.
  function automatic logic [DW-1:0] hit(input logic [NSYM-1:0] f);
    hit = 32'h0;
    for (int i = 0; i < NSYM; i++) begin
      if (f[i] && org_x8 && i < NSYM8) hit[i*SYM8 +: SYM8] = 8'hff;
      if (f[i] && !org_x8) hit[i*SYM4 +: SYM4] = 4'hf;
    end
  endfunction : hit

  // Start empty and healthy so that unwritten words carry a consistent check byte.
  initial begin
    for (int b = 0; b < NBANK; b++) begin
      bad[b] = 8'h00;
      for (int w = 0; w < 4; w++) store[b][w] = 40'h0;
    end
    {busy, mem_ack, mem_link_err, mem_rsp_par} = 4'h0;
    {mem_rdata, mem_rcheck, mem_bad} = 48'h0;
    {nerr, dly, cnt} = {32'h0, 32'h0, 32'h0};
  end

  // One answer per command; a released read bus keeps toggling instead of holding data.
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_link_err <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_valid) begin
      busy <= 1'b1;
      cnt <= dly;
      {cw, cb, ca} <= {mem_write, mem_bank, mem_addr[1:0]};
      cdat <= {mem_wdata, mem_wcheck};
    end else if (busy && cnt > 0) begin
      cnt <= cnt - 1;
    end else if (busy) begin
      busy <= 1'b0;
      mem_ack <= 1'b1;
      mem_link_err <= nerr > 0;
      if (nerr > 0) nerr <= nerr - 1;
      if (cw) store[cb][ca] <= cdat;
      rd = store[cb][ca] ^ {hit(bad[cb]), 8'h00};
      {mem_rdata, mem_rcheck} <= rd;
      mem_bad <= bad[cb];
      mem_rsp_par <= ^rd;
    end
  end
endmodule : mmsc_dimm_model
`default_nettype wire

// *** mmsc_pkg.sv ***
`default_nettype none
package mmsc_pkg;
  // Data path geometry: 32 data bits, 8 check bits, DRAM symbols of 4 or 8 bits.
  localparam int DW         = 32;
  localparam int CW         = 8;
  localparam int NSYM       = 8;
  localparam int NSYM8      = 4;
  localparam int SYM4       = 4;
  localparam int SYM8       = 8;
  // Four banks; bit 0 of a bank number picks primary (0) or mirror (1) in mirror mode.
  localparam int BW         = 2;
  localparam int NBANK      = 4;
  localparam int NPAIR      = 2;
  localparam int COPY_BIT   = 0;
  localparam int HALF_SHIFT = 1;
  // Correctable error threshold per bank and link retry budget.
  localparam int CNTW       = 3;
  localparam logic [CNTW-1:0] CE_LIMIT = 3'h4;
  localparam int RW         = 2;
  localparam logic [RW-1:0] MAX_RETRY = 2'h3;

  typedef enum logic [1:0] {MMSC_IDLE, MMSC_SEND, MMSC_WAIT} mmsc_state_t;
  typedef enum logic [2:0] {
    MMSC_LOG_CE, MMSC_LOG_UE, MMSC_LOG_FAILOVER, MMSC_LOG_SPARE_START, MMSC_LOG_SPARE_DONE
  } mmsc_log_t;
endpackage : mmsc_pkg
`default_nettype wire

// *** mmsc_redundancy_ctrl.sv ***
// Functional notes
// - Mirror writes: primary first, then mirror copy.
// - Healthy mirror reads may use either copy.
// - Primary uncorrectable: use mirror copy only.
// - Mirror uncorrectable: use primary copy only.
// - One copy bad, other good: log correctable.
// - Both copies bad: log uncorrectable.
// - Mirror mode: skip mirror test, half capacity.
// - Fourth correctable error per bank starts copy.
// - Copy logged; spare replaces bank, same capacity.
// - Sparing and mirroring never both active.
// - Correct one whole failed x4/x8 DRAM.
// - Protect command/address; retry on link error.
`timescale 1ns/100ps
`default_nettype none
module mmsc_redundancy_ctrl
  import mmsc_pkg::*;
#(
  parameter int AW         = 24,
  parameter int CAPW       = 16,
  parameter int COPY_WORDS = 4194304
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             mode_mirror,
  input  wire logic             mode_spare,
  input  wire logic             org_x8,
  input  wire logic [BW-1:0]    spare_bank,
  input  wire logic [CAPW-1:0]  cap_installed,
  input  wire logic [CAPW-1:0]  cap_spare,
  input  wire logic             req_valid,
  input  wire logic             req_write,
  input  wire logic [AW-1:0]    req_addr,
  input  wire logic [DW-1:0]    req_wdata,
  output logic                  req_ready,
  output logic                  rsp_valid,
  output logic [DW-1:0]         rsp_rdata,
  output logic                  rsp_err,
  output logic                  mem_valid,
  output logic                  mem_write,
  output logic [BW-1:0]         mem_bank,
  output logic [AW-BW-1:0]      mem_addr,
  output logic [DW-1:0]         mem_wdata,
  output logic [CW-1:0]         mem_wcheck,
  output logic                  mem_cmd_par,
  input  wire logic             mem_ack,
  input  wire logic             mem_link_err,
  input  wire logic [DW-1:0]    mem_rdata,
  input  wire logic [CW-1:0]    mem_rcheck,
  input  wire logic [NSYM-1:0]  mem_bad,
  input  wire logic             mem_rsp_par,
  output logic                  log_valid,
  output mmsc_log_t             log_kind,
  output logic [BW-1:0]         log_bank,
  output logic                  mirror_test_en,
  output logic [CAPW-1:0]       cap_usable,
  output logic                  cfg_conflict
);
  localparam logic [AW-BW-1:0] COPY_LAST = (AW-BW)'(COPY_WORDS - 1);

  typedef struct packed {
    mmsc_state_t      st;
    logic             req_ready;
    logic             op_write;
    logic             op_copy;
    logic [BW-1:0]    op_bank;
    logic [AW-BW-1:0] op_addr;
    logic [DW-1:0]    op_data;
    logic             wr_second;
    logic             rd_alt;
    logic             rd_sel;
    logic [RW-1:0]    retry;
    logic [NPAIR-1:0] fail_p;
    logic [NPAIR-1:0] fail_m;
    logic             copy_run;
    logic [BW-1:0]    copy_src;
    logic [AW-BW-1:0] copy_ptr;
    logic             remap_on;
    logic [BW-1:0]    remap_from;
    logic             mem_valid;
    logic             mem_write;
    logic [BW-1:0]    mem_bank;
    logic [AW-BW-1:0] mem_addr;
    logic [DW-1:0]    mem_wdata;
    logic [CW-1:0]    mem_wcheck;
    logic             mem_cmd_par;
    logic             rsp_valid;
    logic [DW-1:0]    rsp_rdata;
    logic             rsp_err;
    logic             log_valid;
    mmsc_log_t        log_kind;
    logic [BW-1:0]    log_bank;
    logic             mirror_test_en;
    logic [CAPW-1:0]  cap_usable;
    logic             cfg_conflict;
  } mmsc_core_t;

  mmsc_core_t       core;
  mmsc_core_t       next_core;
  logic             mir;
  logic             spr;
  logic [DW+1:0]    ecc_w;
  logic             ue_eff;
  logic             link_bad;
  logic [NBANK-1:0] inc_v;
  logic [NBANK-1:0] clr_v;
  logic [NBANK-1:0] hit;
  logic             start_ok;
  logic [BW-1:0]    start_bank;

  ////////////////////////////////////////////////////////////////////////////
  // Check symbol: XOR of all DRAM symbols, so one flagged DRAM can be rebuilt.
  function automatic logic [CW-1:0] sym_xor(input logic [DW-1:0] d, input logic x8);
    logic [CW-1:0] s;
    s = '0;
    if (x8) begin
      for (int i = 0; i < NSYM8; i++) s = s ^ d[i*SYM8 +: SYM8];
    end else begin
      for (int i = 0; i < NSYM; i++) s[SYM4-1:0] = s[SYM4-1:0] ^ d[i*SYM4 +: SYM4];
    end
    return s;
  endfunction : sym_xor

  // Returns {uncorrectable, corrected, data}; the buffer flags the failing DRAM.
  function automatic logic [DW+1:0] ecc_fix(input logic [DW-1:0] d, input logic [CW-1:0] c,
                                            input logic [NSYM-1:0] bad, input logic x8);
    logic [CW-1:0]   syn;
    logic [DW-1:0]   f;
    logic [NSYM-1:0] m;
    int              n;
    syn = c ^ sym_xor(d, x8);
    f   = d;
    m   = bad;
    if (x8) m[NSYM-1:NSYM8] = '0;
    if (!x8) syn[CW-1:SYM4] = '0;
    n = $countones(m);
    if (n == 1) begin
      for (int i = 0; i < NSYM8; i++) if (x8 && m[i]) f[i*SYM8 +: SYM8] = d[i*SYM8 +: SYM8] ^ syn;
      for (int i = 0; i < NSYM; i++)
        if (!x8 && m[i]) f[i*SYM4 +: SYM4] = d[i*SYM4 +: SYM4] ^ syn[SYM4-1:0];
    end
    return {(n > 1) || (n == 0 && syn != '0), n == 1, f};
  endfunction : ecc_fix

  // A conflicting setting enables neither mode rather than guessing one.
  assign mir      = mode_mirror & ~mode_spare;
  assign spr      = mode_spare & ~mode_mirror;
  assign ecc_w    = ecc_fix(mem_rdata, mem_rcheck, mem_bad, org_x8);
  assign link_bad = mem_link_err | (~core.op_write & ((^{mem_rdata, mem_rcheck}) != mem_rsp_par));
  assign ue_eff   = ecc_w[DW+1] | link_bad;

  ////////////////////////////////////////////////////////////////////////////
  // Per-bank correctable error counters.
  mmsc_cnt_if cif [NBANK] ();
  for (genvar b = 0; b < NBANK; b++) begin : g_cnt
    assign cif[b].inc = inc_v[b];
    assign cif[b].clr = clr_v[b];
    assign hit[b]     = cif[b].hit;
    mmsc_ce_counter u_cnt (.clk(clk), .srst(srst), .port_if(cif[b]));
  end

  // Lowest-numbered bank at threshold that is not the spare itself.
  always_comb begin
    start_ok   = '0;
    start_bank = '0;
    for (int b = NBANK - 1; b >= 0; b--) begin
      if (hit[b] && BW'(b) != spare_bank) begin
        start_ok   = '1;
        start_bank = BW'(b);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: host requests, mirror duplication and failover, spare copy.
  always_comb begin
    logic rp;
    rp = req_addr[AW-1];
    next_core = core;
    next_core.mem_valid = '0;
    next_core.rsp_valid = '0;
    next_core.log_valid = '0;
    next_core.req_ready = '0;
    inc_v = '0;
    clr_v = '0;
    next_core.cfg_conflict   = mode_mirror & mode_spare;
    next_core.mirror_test_en = ~mir;
    // The spare bank is held back from the start, so swapping it in keeps capacity.
    next_core.cap_usable = mir ? (cap_installed >> HALF_SHIFT) :
                           spr ? (cap_installed - cap_spare) : cap_installed;
    unique case (core.st)
      MMSC_IDLE: begin
        if (core.copy_run) begin
          next_core.op_copy  = '1;
          next_core.op_write = '0;
          next_core.op_bank  = core.copy_src;
          next_core.op_addr  = core.copy_ptr;
          next_core.retry    = '0;
          next_core.st       = MMSC_SEND;
        end else if (req_valid && core.req_ready) begin
          next_core.op_copy   = '0;
          next_core.op_write  = req_write;
          next_core.op_data   = req_wdata;
          next_core.op_addr   = req_addr[AW-BW-1:0];
          next_core.op_bank   = req_addr[AW-1 -: BW];
          next_core.wr_second = '0;
          next_core.rd_alt    = '0;
          next_core.retry     = '0;
          next_core.st        = MMSC_SEND;
          if (mir) begin
            next_core.op_bank[COPY_BIT] = '0;
            if (core.fail_p[rp]) begin
              next_core.op_bank[COPY_BIT] = '1;
            end else if (core.fail_m[rp]) begin
              next_core.op_bank[COPY_BIT] = '0;
            end else if (req_write) begin
              next_core.wr_second = '1;
            end else begin
              // Alternating copies spreads read wear across both halves.
              next_core.op_bank[COPY_BIT] = core.rd_sel;
              next_core.rd_sel = ~core.rd_sel;
            end
          end else if (spr && core.remap_on && req_addr[AW-1 -: BW] == core.remap_from) begin
            next_core.op_bank = spare_bank;
          end
        end else if (spr && !core.remap_on && start_ok) begin
          next_core.copy_run  = '1;
          next_core.copy_src  = start_bank;
          next_core.copy_ptr  = '0;
          next_core.log_valid = '1;
          next_core.log_kind  = MMSC_LOG_SPARE_START;
          next_core.log_bank  = start_bank;
        end else begin
          next_core.req_ready = '1;
        end
      end
      MMSC_SEND: begin
        // Command, address and data all go out under one parity bit.
        next_core.mem_valid   = '1;
        next_core.mem_write   = core.op_write;
        next_core.mem_bank    = core.op_bank;
        next_core.mem_addr    = core.op_addr;
        next_core.mem_wdata   = core.op_data;
        next_core.mem_wcheck  = sym_xor(core.op_data, org_x8);
        next_core.mem_cmd_par = ^{core.op_write, core.op_bank, core.op_addr, core.op_data,
                                  sym_xor(core.op_data, org_x8)};
        next_core.st          = MMSC_WAIT;
      end
      MMSC_WAIT: begin
        if (mem_ack && link_bad && core.retry != MAX_RETRY) begin
          next_core.retry = core.retry + 1'b1;
          next_core.st    = MMSC_SEND;
        end else if (mem_ack) begin
          next_core.retry = '0;
          next_core.st    = MMSC_IDLE;
          if (core.op_write && core.wr_second) begin
            next_core.wr_second = '0;
            next_core.op_bank[COPY_BIT] = '1;
            next_core.st = MMSC_SEND;
          end else if (core.op_write && core.op_copy) begin
            if (core.copy_ptr == COPY_LAST) begin
              next_core.copy_run   = '0;
              next_core.remap_on   = '1;
              next_core.remap_from = core.copy_src;
              clr_v[core.copy_src] = '1;
              next_core.log_valid  = '1;
              next_core.log_kind   = MMSC_LOG_SPARE_DONE;
              next_core.log_bank   = spare_bank;
            end else begin
              next_core.copy_ptr = core.copy_ptr + 1'b1;
            end
          end else if (core.op_write) begin
            next_core.rsp_valid = '1;
            next_core.rsp_err   = link_bad;
            next_core.log_valid = link_bad;
            next_core.log_kind  = MMSC_LOG_UE;
            next_core.log_bank  = core.op_bank;
          end else if (core.op_copy) begin
            next_core.op_write = '1;
            next_core.op_data  = ecc_w[DW-1:0];
            next_core.op_bank  = spare_bank;
            next_core.st       = MMSC_SEND;
          end else if (mir && ue_eff && !core.rd_alt && !core.fail_p[core.op_bank[BW-1]] &&
                       !core.fail_m[core.op_bank[BW-1]]) begin
            // Mark the bad copy and fetch the same word from the other one.
            if (core.op_bank[COPY_BIT]) next_core.fail_m[core.op_bank[BW-1]] = '1;
            else next_core.fail_p[core.op_bank[BW-1]] = '1;
            next_core.op_bank[COPY_BIT] = ~core.op_bank[COPY_BIT];
            next_core.rd_alt    = '1;
            next_core.log_valid = '1;
            next_core.log_kind  = MMSC_LOG_FAILOVER;
            next_core.log_bank  = core.op_bank;
            next_core.st        = MMSC_SEND;
          end else begin
            next_core.rsp_valid = '1;
            next_core.rsp_rdata = ecc_w[DW-1:0];
            next_core.rsp_err   = ue_eff;
            next_core.log_valid = ue_eff | ecc_w[DW] | core.rd_alt;
            next_core.log_kind  = ue_eff ? MMSC_LOG_UE : MMSC_LOG_CE;
            next_core.log_bank  = core.op_bank;
            inc_v[core.op_bank] = spr & ecc_w[DW] & ~ue_eff;
          end
        end
      end
      default: next_core.st = MMSC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      core <= '0;
    end else begin
      core <= next_core;
    end
  end

  // Every output is a field of the state register.
  assign req_ready      = core.req_ready;
  assign rsp_valid      = core.rsp_valid;
  assign rsp_rdata      = core.rsp_rdata;
  assign rsp_err        = core.rsp_err;
  assign mem_valid      = core.mem_valid;
  assign mem_write      = core.mem_write;
  assign mem_bank       = core.mem_bank;
  assign mem_addr       = core.mem_addr;
  assign mem_wdata      = core.mem_wdata;
  assign mem_wcheck     = core.mem_wcheck;
  assign mem_cmd_par    = core.mem_cmd_par;
  assign log_valid      = core.log_valid;
  assign log_kind       = core.log_kind;
  assign log_bank       = core.log_bank;
  assign mirror_test_en = core.mirror_test_en;
  assign cap_usable     = core.cap_usable;
  assign cfg_conflict   = core.cfg_conflict;
  logic rp_a;
  assign rp_a = req_addr[AW-1];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence primary_done_s;
    core.st == MMSC_WAIT && mem_ack && !link_bad && core.op_write && core.wr_second;
  endsequence
  sequence mirror_sent_s;
    core.st == MMSC_SEND && core.op_bank[COPY_BIT] ##1 mem_valid && mem_write && mem_bank[COPY_BIT];
  endsequence
  sequence link_retry_s;
    core.st == MMSC_WAIT && mem_ack && mem_link_err && core.retry != MAX_RETRY;
  endsequence

  mirror_write_order_a: assert property (primary_done_s |=> mirror_sent_s)
    else $error("mirror copy write did not follow primary write");
  read_copy_alt_a: assert property (core.st == MMSC_IDLE && req_valid && req_ready && !req_write &&
      mir && !core.fail_p[rp_a] && !core.fail_m[rp_a]
      |=> core.op_bank[COPY_BIT] == $past(core.rd_sel) && core.rd_sel != $past(core.rd_sel))
    else $error("healthy mirror read did not alternate copies");
  primary_failover_a: assert property (core.st == MMSC_IDLE && req_valid && req_ready && mir &&
      core.fail_p[rp_a] |=> core.op_bank[COPY_BIT] && !core.wr_second)
    else $error("access after primary failure not routed to mirror");
  mirror_failover_a: assert property (core.st == MMSC_IDLE && req_valid && req_ready && mir &&
      !core.fail_p[rp_a] && core.fail_m[rp_a] |=> !core.op_bank[COPY_BIT] && !core.wr_second)
    else $error("access after mirror failure not routed to primary");
  other_copy_ce_a: assert property (core.st == MMSC_WAIT && mem_ack && !link_bad && core.rd_alt &&
      !core.op_write && !ecc_w[DW+1] |=> log_valid && log_kind == MMSC_LOG_CE && rsp_valid)
    else $error("recovered read not logged as correctable");
  both_bad_ue_a: assert property (rsp_valid && rsp_err |-> log_valid && log_kind == MMSC_LOG_UE)
    else $error("failed response without uncorrectable log");
  half_capacity_a: assert property (mode_mirror && !mode_spare |=>
      !mirror_test_en && cap_usable == ($past(cap_installed) >> HALF_SHIFT))
    else $error("mirror mode capacity or test skip wrong");
  spare_start_a: assert property ($rose(core.copy_run) |-> log_valid &&
      log_kind == MMSC_LOG_SPARE_START && $past(hit[start_bank]) && $past(spr))
    else $error("spare copy start not logged or not caused by threshold");
  spare_done_a: assert property ($rose(core.remap_on) |-> log_valid &&
      log_kind == MMSC_LOG_SPARE_DONE && !core.copy_run)
    else $error("spare completion not logged");
  no_dual_mode_a: assert property (mode_mirror && mode_spare && core.st == MMSC_IDLE && req_valid &&
      req_ready |=> !core.wr_second && core.op_bank == $past(req_addr[AW-1 -: BW]))
    else $error("redundancy mode active under conflicting setting");
  link_retry_a: assert property (link_retry_s |=> core.st == MMSC_SEND ##1
      mem_valid && mem_addr == $past(mem_addr, 2))
    else $error("link error not retried with same address");
endmodule : mmsc_redundancy_ctrl
`default_nettype wire
